/* File: core/eep_top.sv */
// Bulk-programming and protection control of a three-wire serial memory.
// Assumes chip select, serial clock and data-in arrive asynchronously as
// pins and that the serial clock is far slower than i_mclk.
`timescale 1ns/10ps
`include "eep_params.svh"

module eep_top
    import eep_pkg::*;
#(
    parameter int AW            = `EEP_ADDR_W,
    parameter int DW            = `EEP_DATA_W,
    parameter int P_PROG_CYCLES = `EEP_PROG_CYC
) (
    input  wire logic          i_mclk,
    input  wire logic          i_rstn,
    input  wire logic          i_chip_select,
    input  wire logic          i_serial_clock_in,
    input  wire logic          i_serial_data_in,
    input  wire logic [AW-1:0] i_dbg_addr,
    output logic               o_serial_data_out,
    output logic               o_serial_data_out_oe,
    output logic               o_program_enabled,
    output logic               o_busy,
    output logic      [DW-1:0] o_dbg_data
);

    localparam int ADDR_END = `EEP_OPCODE_BITS + AW;
    localparam int DATA_END = ADDR_END + DW;
    localparam int CW       = $clog2(DATA_END + 1);
    localparam int TW       = $clog2(P_PROG_CYCLES + 1);

    // The shift registers need at least two bits to drop their top bit.
    if (AW < `EEP_SUBOP_BITS || DW < 2 || P_PROG_CYCLES < 1) begin : g_bad_param
        $error("eep_top: parameters out of range");
    end

    // Reset release is synchronised; assertion stays asynchronous.
    logic rst_meta_reg;
    logic rst_sync;

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_meta_reg <= 1'b0;
            rst_sync     <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync     <= rst_meta_reg;
        end
    end

    logic [2:0] pins_s;
    logic       cs_s;
    logic       sk_s;
    logic       di_s;

    eep_sync #(
        .W (3)
    ) u_sync (
        .i_clk   (i_mclk),
        .i_rst_n (rst_sync),
        .i_async ({i_chip_select, i_serial_clock_in, i_serial_data_in}),
        .o_sync  (pins_s)
    );

    assign cs_s = pins_s[2];
    assign sk_s = pins_s[1];
    assign di_s = pins_s[0];

    // Edge detection works on the synchronised copies only.
    logic sk_d_reg;
    logic sk_rise;

    always_ff @(posedge i_mclk or negedge rst_sync) begin
        if (!rst_sync) begin
            sk_d_reg <= 1'b0;
        end else begin
            sk_d_reg <= sk_s;
        end
    end

    assign sk_rise = sk_s & ~sk_d_reg;

    eep_state_t    state_reg;
    eep_state_t    state_next;
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    eep_op_t       op_reg;
    eep_op_t       op_next;
    logic [AW-1:0] addr_reg;
    logic [AW-1:0] addr_next;
    logic [DW-1:0] data_reg;
    logic [DW-1:0] data_next;
    logic [TW-1:0] timer_reg;
    logic [TW-1:0] timer_next;
    eep_prog_t     prog_reg;
    eep_prog_t     prog_next;
    logic          prog_en_reg;
    logic          prog_en_next;
    logic          do_reg;
    logic          do_next;
    logic          do_oe_reg;
    logic          do_oe_next;
    logic          busy_reg;
    logic          busy_next;

    eep_ext_t  subop;
    logic      addr_done;
    logic      data_done;
    logic      en_hit;
    logic      dis_hit;
    eep_prog_t commit_kind;

    assign subop     = eep_ext_t'(addr_reg[AW-1 -: `EEP_SUBOP_BITS]);
    assign addr_done = (cnt_reg >= CW'(ADDR_END));
    assign data_done = (cnt_reg >= CW'(DATA_END));
    // The switch happens on the edge after the last address bit was taken.
    assign en_hit    = (state_reg == ST_RECV) && cs_s && sk_rise && (op_reg == OP_EXT)
                       && (cnt_reg == CW'(ADDR_END)) && (subop == PROGRAM_ENABLE_CMD);
    assign dis_hit   = (state_reg == ST_RECV) && cs_s && sk_rise && (op_reg == OP_EXT)
                       && (cnt_reg == CW'(ADDR_END)) && (subop == PROGRAM_DISABLE_CMD);

    // Which operation a falling select would trigger now; short frames trigger none.
    always_comb begin
        commit_kind = PROG_NONE;
        case (op_reg)
            OP_WRITE: begin
                if (data_done) begin
                    commit_kind = PROG_WORD;
                end
            end
            OP_ERASE: begin
                if (addr_done) begin
                    commit_kind = PROG_ERASE_WORD;
                end
            end
            OP_EXT: begin
                if (subop == WRITE_ALL_CMD && data_done) begin
                    commit_kind = PROG_WRITE_ALL;
                end else if (subop == ERASE_ALL_CMD && addr_done) begin
                    commit_kind = PROG_ERASE_ALL;
                end
            end
            default: commit_kind = PROG_NONE;
        endcase
    end

    always_comb begin
        state_next   = state_reg;
        cnt_next     = cnt_reg;
        op_next      = op_reg;
        addr_next    = addr_reg;
        data_next    = data_reg;
        timer_next   = timer_reg;
        prog_next    = PROG_NONE;
        prog_en_next = prog_en_reg;
        case (state_reg)
            ST_IDLE: begin
                // Low data-in edges before the start bit are dummy cycles.
                if (cs_s && sk_rise && di_s) begin
                    state_next = ST_RECV;
                    cnt_next   = '0;
                end
            end
            ST_RECV: begin
                if (!cs_s) begin
                    state_next = ST_IDLE;
                    if (commit_kind != PROG_NONE && prog_en_reg) begin
                        prog_next  = commit_kind;
                        state_next = ST_BUSY;
                        timer_next = TW'(P_PROG_CYCLES - 1);
                    end
                end else if (sk_rise) begin
                    if (en_hit) begin
                        prog_en_next = 1'b1;
                    end else if (dis_hit) begin
                        prog_en_next = 1'b0;
                    end
                    // Bits past the first data word are ignored.
                    if (cnt_reg < CW'(`EEP_OPCODE_BITS)) begin
                        op_next = eep_op_t'({op_reg[0], di_s});
                    end else if (cnt_reg < CW'(ADDR_END)) begin
                        addr_next = {addr_reg[AW-2:0], di_s};
                    end else if (cnt_reg < CW'(DATA_END)) begin
                        data_next = {data_reg[DW-2:0], di_s};
                    end
                    if (cnt_reg <= CW'(DATA_END)) begin
                        cnt_next = cnt_reg + CW'(1);
                    end
                end
            end
            ST_BUSY: begin
                // Serial clock and data-in are not looked at while programming.
                if (timer_reg == '0) begin
                    state_next = cs_s ? ST_READY : ST_IDLE;
                end else begin
                    timer_next = timer_reg - TW'(1);
                end
            end
            ST_READY: begin
                if (!cs_s) begin
                    state_next = ST_IDLE;
                end else if (sk_rise && di_s) begin
                    // A high data-in here is taken as a start bit.
                    state_next = ST_RECV;
                    cnt_next   = '0;
                end
            end
            default: state_next = ST_IDLE;
        endcase
        if (state_next == ST_RECV && state_reg != ST_RECV) begin
            op_next   = OP_EXT;
            addr_next = '0;
            data_next = '0;
        end
    end

    // Data-out is only driven during verify; it floats as soon as a new frame starts.
    always_comb begin
        do_oe_next = ((state_next == ST_BUSY) && cs_s) || (state_next == ST_READY);
        do_next    = (state_next == ST_READY);
        busy_next  = (state_next == ST_BUSY);
    end

    always_ff @(posedge i_mclk or negedge rst_sync) begin
        if (!rst_sync) begin
            state_reg   <= ST_IDLE;
            cnt_reg     <= '0;
            op_reg      <= OP_EXT;
            addr_reg    <= '0;
            data_reg    <= '0;
            timer_reg   <= '0;
            prog_reg    <= PROG_NONE;
            prog_en_reg <= `EEP_PROG_EN_RST;
            do_reg      <= 1'b0;
            do_oe_reg   <= 1'b0;
            busy_reg    <= 1'b0;
        end else begin
            state_reg   <= state_next;
            cnt_reg     <= cnt_next;
            op_reg      <= op_next;
            addr_reg    <= addr_next;
            data_reg    <= data_next;
            timer_reg   <= timer_next;
            prog_reg    <= prog_next;
            prog_en_reg <= prog_en_next;
            do_reg      <= do_next;
            do_oe_reg   <= do_oe_next;
            busy_reg    <= busy_next;
        end
    end

    eep_array #(
        .AW (AW),
        .DW (DW)
    ) u_array (
        .i_clk     (i_mclk),
        .i_rst_n   (rst_sync),
        .i_prog    (prog_reg),
        .i_addr    (addr_reg),
        .i_data    (data_reg),
        .i_rd_addr (i_dbg_addr),
        .o_rd_data (o_dbg_data)
    );

    assign o_serial_data_out    = do_reg;
    assign o_serial_data_out_oe = do_oe_reg;
    assign o_program_enabled    = prog_en_reg;
    assign o_busy               = busy_reg;

    // Helper terms sampled by the checks below.
    logic was_write_ok;
    logic cancel_hit;
    logic start_at_ready;
    assign was_write_ok   = (state_reg == ST_RECV) && !cs_s && (op_reg == OP_WRITE)
                            && data_done && prog_en_reg;
    assign cancel_hit     = (state_reg == ST_RECV) && !cs_s && !data_done
                            && ((op_reg == OP_WRITE)
                                || ((op_reg == OP_EXT) && (subop == WRITE_ALL_CMD)));
    assign start_at_ready = (state_reg == ST_READY) && cs_s && sk_rise && di_s;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!rst_sync);

    AST_EN_CAUSE: assert property ($rose(prog_en_reg) |-> $past(en_hit))
        else $error("program enable rose without an enable instruction");
    AST_DIS_CAUSE: assert property ($fell(prog_en_reg) |-> $past(dis_hit))
        else $error("program enable fell without a disable instruction");
    AST_NO_PROG_DISABLED: assert property (
        (prog_reg != PROG_NONE) |-> $past(prog_en_reg))
        else $error("array programmed while program-disabled");
    AST_WRALL_FULL: assert property (
        (prog_reg == PROG_WRITE_ALL) |-> $past(data_done) && !$past(cs_s))
        else $error("write-all triggered without a full word");
    AST_ERALL_ADDR: assert property (
        (prog_reg == PROG_ERASE_ALL) |-> $past(addr_done) && $past(busy_next))
        else $error("erase-all triggered before the address was complete");
    AST_CANCEL: assert property (cancel_hit |=> (prog_reg == PROG_NONE) && !busy_reg)
        else $error("short write frame was not cancelled");
    AST_WRITE_KEPT: assert property (
        was_write_ok |=> (prog_reg == PROG_WORD) ##1 busy_reg)
        else $error("complete write frame was not programmed");
    AST_BUSY_LOW: assert property (
        (state_reg == ST_BUSY) && cs_s && (timer_reg != '0) |=> do_oe_reg && !do_reg)
        else $error("data-out not low while busy");
    AST_BUSY_HOLD: assert property (
        (state_reg == ST_BUSY) && (timer_reg != '0) |=> (state_reg == ST_BUSY))
        else $error("busy ended before its time");
    AST_FLOAT_START: assert property (
        start_at_ready |=> !do_oe_reg && (state_reg == ST_RECV) && (cnt_reg == '0))
        else $error("data-out not floated on start bit at ready");
    AST_DUMMY: assert property (
        (state_reg == ST_IDLE) && sk_rise && !di_s |=> (state_reg == ST_IDLE))
        else $error("dummy cycle was taken as a start bit");

    COV_WRITE_ALL: cover property (prog_reg == PROG_WRITE_ALL);
    COV_ERASE_ALL: cover property (prog_reg == PROG_ERASE_ALL);
    COV_ENABLE: cover property ($rose(prog_en_reg));
    COV_VERIFY_START: cover property (start_at_ready);

endmodule // eep_top

/* File: core/eep_params.svh */
// Constants of the bulk-programming control of a three-wire serial memory.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef EEP_PARAMS_SVH
`define EEP_PARAMS_SVH

// Array shape: 64 words of 16 bits.
`define EEP_ADDR_W      6
`define EEP_DATA_W      16

// Frame layout after the start bit: two opcode bits, then address, then data.
`define EEP_OPCODE_BITS 2
`define EEP_SUBOP_BITS  2

// Longest programming time and the system clock rate.
`define EEP_T_PROG_MS   10
`define EEP_CLK_MHZ     200
// Longest time rounds down to whole cycles: 10 ms at 200 MHz.
`define EEP_PROG_CYC    (`EEP_T_PROG_MS * 1000 * `EEP_CLK_MHZ)

// Reset value of the program-enable state: disabled.
`define EEP_PROG_EN_RST 1'b0

`endif

/* File: core/eep_pkg.sv */
// Types shared by the bulk-programming control modules.
// Assumes eep_params.svh is reachable on the include path.
`include "eep_params.svh"

package eep_pkg;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_RECV  = 2'b01,
        ST_BUSY  = 2'b10,
        ST_READY = 2'b11
    } eep_state_t;

    typedef enum logic [1:0] {
        OP_EXT   = 2'b00,
        OP_WRITE = 2'b01,
        OP_READ  = 2'b10,
        OP_ERASE = 2'b11
    } eep_op_t;

    typedef enum logic [1:0] {
        PROGRAM_DISABLE_CMD = 2'b00,
        WRITE_ALL_CMD       = 2'b01,
        ERASE_ALL_CMD       = 2'b10,
        PROGRAM_ENABLE_CMD  = 2'b11
    } eep_ext_t;

    typedef enum logic [2:0] {
        PROG_NONE       = 3'b000,
        PROG_WORD       = 3'b001,
        PROG_ERASE_WORD = 3'b010,
        PROG_WRITE_ALL  = 3'b011,
        PROG_ERASE_ALL  = 3'b100
    } eep_prog_t;

endpackage

/* File: core/eep_sync.sv */
// Two-flip-flop synchroniser for a group of independent levels.
// Assumes each bit is a slow level or clock from outside the i_clk domain.
`timescale 1ns/10ps

module eep_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);

    if (W < 1) begin : g_bad_param
        $error("eep_sync: width out of range");
    end

    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;

endmodule // eep_sync

/* File: core/eep_array.sv */
// Word array, set to all ones by reset, with single-cycle word and whole-array updates.
// Assumes a one-cycle program pulse from the control; reads are registered.
`timescale 1ns/10ps
`include "eep_params.svh"

module eep_array
    import eep_pkg::*;
#(
    parameter int AW = `EEP_ADDR_W,
    parameter int DW = `EEP_DATA_W
) (
    input  wire logic          i_clk,
    input  wire logic          i_rst_n,
    input  wire eep_prog_t     i_prog,
    input  wire logic [AW-1:0] i_addr,
    input  wire logic [DW-1:0] i_data,
    input  wire logic [AW-1:0] i_rd_addr,
    output logic      [DW-1:0] o_rd_data
);

    localparam int DEPTH = 1 << AW;

    if (AW < 1 || DW < 1) begin : g_bad_param
        $error("eep_array: parameters out of range");
    end

    logic [DW-1:0] mem_reg  [DEPTH];
    logic [DW-1:0] mem_next [DEPTH];
    logic [DW-1:0] rd_reg;
    logic [DW-1:0] rd_next;

    // Every entry decides its own update, so a whole-array operation costs one cycle.
    for (genvar i = 0; i < DEPTH; i++) begin : g_word
        always_comb begin
            mem_next[i] = mem_reg[i];
            case (i_prog)
                PROG_WRITE_ALL: mem_next[i] = i_data;
                PROG_ERASE_ALL: mem_next[i] = {DW{1'b1}};
                PROG_WORD: begin
                    if (i_addr == AW'(i)) begin
                        mem_next[i] = i_data;
                    end
                end
                PROG_ERASE_WORD: begin
                    if (i_addr == AW'(i)) begin
                        mem_next[i] = {DW{1'b1}};
                    end
                end
                default: mem_next[i] = mem_reg[i];
            endcase
        end

        always_ff @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                mem_reg[i] <= {DW{1'b1}};
            end else begin
                mem_reg[i] <= mem_next[i];
            end
        end
    end

    always_comb begin
        rd_next = mem_reg[i_rd_addr];
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_reg <= '0;
        end else begin
            rd_reg <= rd_next;
        end
    end

    assign o_rd_data = rd_reg;

endmodule // eep_array

/* File: tb/eep_host_model.sv */
// Host-side model of the three-wire link: drives select, serial clock and data-in.
// Assumes the bench calls its tasks hierarchically; every change lands on falling i_mclk.
`timescale 1ns/10ps

module eep_host_model #(
    parameter int P_HALF_LO   = 13,
    parameter int P_HALF_HI   = 12,
    parameter int P_POWER_CYC = 200
) (
    input  wire logic i_mclk,
    output logic      o_chip_select,
    output logic      o_serial_clock_in,
    output logic      o_serial_data_in
);
    // Select stays low through power-up; the wait is shortened to keep the run brief.
    initial begin
        o_chip_select     = 1'b0;
        o_serial_clock_in = 1'b0;
        o_serial_data_in  = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge i_mclk);
    endtask

    task automatic power_up_wait();
        tick(P_POWER_CYC);
    endtask

    // Lowering select ends the frame: a short one is dropped, a complete write or erase one starts programming if enabled.
    task automatic sel(input logic v);
        o_serial_data_in = 1'b0;
        o_chip_select    = v;
        tick(6);
    endtask

    // Sends n bits MSB first from v; the clock stands low outside frames.
    task automatic bits(input logic [23:0] v, input int n);
        for (int k = 0; k < n; k++) begin
            o_serial_data_in = v[23-k];
            tick(P_HALF_LO);
            o_serial_clock_in = 1'b1;
            tick(P_HALF_HI);
            o_serial_clock_in = 1'b0;
        end
        // Data-in rests low so a verify phase never sees a false start.
        o_serial_data_in = 1'b0;
    endtask
endmodule // eep_host_model

/* File: tb/eep_top_tb.sv */
// Self-checking bench of the bulk-programming control, driving the link through the host model.
// Assumes eep_params.svh on the include path and a shortened programming time.
`timescale 1ns/10ps
`include "eep_params.svh"

`define CHK(got, exp) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) begin \
            fail_count++; \
            $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
        end \
    end

module eep_top_tb;
    localparam int AW     = `EEP_ADDR_W;
    localparam int DW     = `EEP_DATA_W;
    localparam int P_PROG = 400;

    logic          mclk;
    logic          rst_n;
    logic [AW-1:0] dbg_addr;
    logic          cs;
    logic          sk;
    logic          di;
    logic          dout;
    logic          dout_oe;
    logic          prog_en;
    logic          busy;
    logic [DW-1:0] dbg_data;
    int            fail_count;
    int            comparisons;
    int            busy_run;
    int            busy_len;

    eep_top #(.P_PROG_CYCLES(P_PROG)) u_dut (
        .i_mclk              (mclk),
        .i_rstn              (rst_n),
        .i_chip_select       (cs),
        .i_serial_clock_in   (sk),
        .i_serial_data_in    (di),
        .i_dbg_addr          (dbg_addr),
        .o_serial_data_out   (dout),
        .o_serial_data_out_oe(dout_oe),
        .o_program_enabled   (prog_en),
        .o_busy              (busy),
        .o_dbg_data          (dbg_data)
    );

    eep_host_model u_host (
        .i_mclk           (mclk),
        .o_chip_select    (cs),
        .o_serial_clock_in(sk),
        .o_serial_data_in (di)
    );

    always #2.5 mclk = ~mclk;

    // Length of the last busy stretch, in system clock cycles.
    always @(posedge mclk) begin
        if (busy === 1'b1) begin
            busy_run <= busy_run + 1;
        end else begin
            if (busy_run != 0) begin
                busy_len <= busy_run;
            end
            busy_run <= 0;
        end
    end

    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic read_word(input int a, input logic [DW-1:0] exp);
        dbg_addr = a[AW-1:0];
        tick(2);
        `CHK(dbg_data, exp);
    endtask

    task automatic check_all(input logic [DW-1:0] exp);
        for (int a = 0; a < (1 << AW); a++) begin
            read_word(a, exp);
        end
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 2000) begin
            tick(1);
            n++;
        end
        if (n >= 2000) begin
            fail_count++;
        end
    endtask

    task automatic frame(input logic [23:0] v, input int n);
        u_host.bits(24'h800000, 1);
        u_host.bits(v, n);
    endtask

    task automatic cmd(input logic [23:0] v, input int n, input int extra);
        u_host.sel(1'b1);
        frame(v, n);
        u_host.bits(24'h000000, extra);
        u_host.sel(1'b0);
        tick(8);
        wait_idle();
    endtask

    task automatic t_power_on();
        `CHK(prog_en, 1'b0);
        check_all(16'hffff);
        $display("test power_on done");
    endtask

    task automatic t_locked();
        cmd({8'h10, 16'h1234}, 24, 0);
        `CHK(busy_len, 0);
        check_all(16'hffff);
        $display("test locked done");
    endtask

    task automatic t_enable();
        u_host.sel(1'b1);
        u_host.bits(24'h000000, 3);
        frame(24'h300000, 8);
        tick(4);
        `CHK(prog_en, 1'b0);
        u_host.bits(24'h000000, 1);
        tick(4);
        `CHK(prog_en, 1'b1);
        u_host.sel(1'b0);
        $display("test enable done");
    endtask

    task automatic t_write_all();
        cmd({8'h10, 16'h1234}, 24, 0);
        check_all(16'h1234);
        u_host.sel(1'b1);
        frame({8'h1f, 16'hedcb}, 24);
        u_host.sel(1'b0);
        tick(8);
        `CHK(busy, 1'b1);
        u_host.sel(1'b1);
        `CHK({dout_oe, dout}, 2'b10);
        u_host.bits(24'hffffff, 2);
        wait_idle();
        tick(4);
        `CHK({dout_oe, dout}, 2'b11);
        `CHK(busy_len, P_PROG);
        u_host.bits(24'h800000, 1);
        tick(4);
        `CHK(dout_oe, 1'b0);
        u_host.sel(1'b0);
        tick(4);
        `CHK(busy, 1'b0);
        check_all(16'hedcb);
        $display("test write_all done");
    endtask

    task automatic t_erase_all();
        cmd(24'hc40000, 7, 0);
        read_word(4, 16'hedcb);
        cmd(24'hc50000, 8, 0);
        read_word(5, 16'hffff);
        read_word(4, 16'hedcb);
        cmd(24'h2a0000, 8, 0);
        check_all(16'hffff);
        // A read frame must never start a programming cycle.
        busy_len = 0;
        cmd({8'h85, 16'h0000}, 24, 0);
        `CHK(busy_len, 0);
        $display("test erase_all done");
    endtask

    task automatic t_cancel();
        busy_len = 0;
        cmd({8'h45, 16'h0f0f}, 23, 0);
        `CHK(busy_len, 0);
        read_word(5, 16'hffff);
        cmd({8'h45, 16'h0f0f}, 24, 1);
        read_word(5, 16'h0f0f);
        read_word(4, 16'hffff);
        $display("test cancel done");
    endtask

    task automatic t_disable();
        cmd(24'h000000, 8, 1);
        `CHK(prog_en, 1'b0);
        busy_len = 0;
        cmd(24'h200000, 8, 0);
        `CHK(busy_len, 0);
        read_word(5, 16'h0f0f);
        $display("test disable done");
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        mclk        = 1'b0;
        rst_n       = 1'b0;
        dbg_addr    = '0;
        fail_count  = 0;
        comparisons = 0;
        busy_run    = 0;
        busy_len    = 0;
        repeat (6) @(posedge mclk);
        @(negedge mclk);
        rst_n = 1'b1;
        u_host.power_up_wait();
        t_power_on();
        t_locked();
        t_enable();
        t_write_all();
        t_erase_all();
        t_cancel();
        t_disable();
        print_verdict();
    end

    // Tests take roughly 41 us; a hang is cut short well beyond that.
    initial begin
        #400000;
        fail_count++;
        print_verdict();
    end
endmodule // eep_top_tb
